// [shared/lpm_pkg.sv]
// Functional notes
// - sleep mode select 11 stop, 10 wait, 01 doze, 00 run.
// - sleep mode select is readable and writable in every mode.
// - clock output stop gate bit 3: 0 pin runs in stop, 1 stops.
// - only a stop instruction enters low power; mode follows the select field.
// - any low-power mode idles the cpu and stops that mode's clocks.
// - in stop the system clock is held stopped low.
// - stop entered only if stop permit is already set at the instruction.
// - leave low power to run only on reset or valid enabled interrupt.
// - waking priority must be strictly above the wake priority threshold; threshold 111 here still admits level seven.
// - waking priority must be above the cpu status mask level.
// - waking request must be unmasked and enabled at its source.
// - wait stops only cpu and memory clocks; peripherals may wake.
// - doze halts cpu like wait; peripherals follow own doze behaviour.
// - stop halts the cpu and every system clock; peripherals cease.
// - after stop, peripherals keep their state and continue.
// - stop disables the dram controller and its refresh counter.
// - a software-disabled peripheral stays disabled in every low-power mode.
// - threshold 000 any, 001..101 need two..six, 11x needs seven.
// - stop permit bit 7: 0 blocks stop entry, 1 permits it.
package lpm_pkg;

    // ==========================================================
    // register map
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_PERIPH = 8;
    localparam logic [3:0] OFS_LOW_POWER_CONTROL = 4'h0;
    localparam logic [3:0] OFS_LOW_POWER_IRQ_CONTROL = 4'h1;
    localparam logic [3:0] OFS_PERIPH_DISABLE = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;

    // ==========================================================
    // field positions
    localparam int SMS_HI = 7;
    localparam int SMS_LO = 6;
    localparam int COSG_BIT = 3;
    localparam int STOP_PERMIT_BIT = 7;
    localparam int WPT_HI = 6;
    localparam int WPT_LO = 4;

    // ==========================================================
    // reset values and writable bits
    localparam logic [7:0] LPC_RST = 8'h00;
    localparam logic [7:0] LPIC_RST = 8'h00;
    localparam logic [7:0] PDIS_RST = 8'h00;
    localparam logic [7:0] LPC_WR_MASK = 8'hc8;
    localparam logic [7:0] LPIC_WR_MASK = 8'hf0;

    // ==========================================================
    // sleep mode codes
    localparam logic [1:0] MODE_STOP = 2'h3;
    localparam logic [1:0] MODE_WAIT = 2'h2;
    localparam logic [1:0] MODE_DOZE = 2'h1;
    localparam logic [1:0] MODE_RUN = 2'h0;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_DOZE = 4'h2,
        ST_WAIT = 4'h4,
        ST_STOP = 4'h8
    } lp_state_t;

    // lowest request level that passes a threshold code
    function automatic logic [2:0] min_wake_level(input logic [2:0] code);
        if (code >= 3'h6) begin
            return 3'h7;
        end
        return 3'(code + 3'h1);
    endfunction

endpackage

// [rtl/lp_wake_qualify.sv]
`timescale 1ns/1ps
module lp_wake_qualify
    import lpm_pkg::*;
(
    // interrupt request
    input wire logic [2:0] irq_level_in,
    input wire logic irq_unmasked_in,
    input wire logic irq_src_en_in,
    // qualifiers
    input wire logic [2:0] cpu_mask_level_in,
    input wire logic [2:0] threshold_in,
    // result
    output logic wake_irq_out
);

    logic above_thresh;
    logic above_mask;
    logic enabled;

    // ==========================================================
    // combinational so a request can wake while clocks are gated
    always_comb begin
        above_thresh = irq_level_in >= min_wake_level(threshold_in);
        above_mask = irq_level_in > cpu_mask_level_in;
        enabled = irq_unmasked_in && irq_src_en_in;
        wake_irq_out = above_thresh && above_mask && enabled;
    end

endmodule

// [rtl/lp_regs.sv]
`timescale 1ns/1ps
module lp_regs
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // block side
    input wire logic [3:0] status_in,
    output logic [7:0] lpc_out,
    output logic [7:0] lpic_out,
    output logic [NUM_PERIPH-1:0] pdis_out
);

    typedef struct packed {
        logic [7:0] lpc;
        logic [7:0] lpic;
        logic [NUM_PERIPH-1:0] pdis;
        logic [DATA_W-1:0] rdata;
    } regs_t;

    localparam regs_t REGS_RST = '{LPC_RST, LPIC_RST, PDIS_RST, 8'h00};

    regs_t r_reg;
    regs_t r_next;

    // ==========================================================
    // access is never gated by the power state
    always_comb begin
        r_next = r_reg;
        r_next.rdata = 8'h00;
        if (reg_wr_in) begin
            if (reg_addr_in == OFS_LOW_POWER_CONTROL) begin
                r_next.lpc = reg_wdata_in & LPC_WR_MASK;
            end else if (reg_addr_in == OFS_LOW_POWER_IRQ_CONTROL) begin
                r_next.lpic = reg_wdata_in & LPIC_WR_MASK;
            end else if (reg_addr_in == OFS_PERIPH_DISABLE) begin
                r_next.pdis = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == OFS_LOW_POWER_CONTROL) begin
                r_next.rdata = r_reg.lpc;
            end else if (reg_addr_in == OFS_LOW_POWER_IRQ_CONTROL) begin
                r_next.rdata = r_reg.lpic;
            end else if (reg_addr_in == OFS_PERIPH_DISABLE) begin
                r_next.rdata = r_reg.pdis;
            end else if (reg_addr_in == OFS_STATUS) begin
                r_next.rdata = {4'h0, status_in};
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            r_reg <= REGS_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign lpc_out = r_reg.lpc;
    assign lpic_out = r_reg.lpic;
    assign pdis_out = r_reg.pdis;
    assign reg_rdata_out = r_reg.rdata;

endmodule

// [rtl/low_power_mode_control.sv]
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
module low_power_mode_control
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // cpu core
    input wire logic stop_exec_in,
    input wire logic [2:0] cpu_mask_level_in,
    // interrupt controller
    input wire logic [2:0] irq_level_in,
    input wire logic irq_unmasked_in,
    input wire logic irq_src_en_in,
    // clock gating
    output logic cpu_clk_en_out,
    output logic mem_clk_en_out,
    output logic sys_clk_en_out,
    output logic [NUM_PERIPH-1:0] periph_clk_en_out,
    output logic periph_doze_out,
    output logic clock_output_pin_en_out,
    // system
    output logic dram_ctrl_stop_out,
    output logic wake_out
);

    typedef struct packed {
        lp_state_t state;
        logic cpu_en;
        logic mem_en;
        logic sys_en;
        logic doze;
        logic pin_clk_en;
        logic dram_stop;
        logic wake;
        logic [NUM_PERIPH-1:0] periph_en;
    } ctl_t;

    localparam ctl_t CTL_RST = '{
        ST_RUN, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, ~PDIS_RST
    };

    ctl_t c_reg;
    ctl_t c_next;

    logic [7:0] lpc;
    logic [7:0] lpic;
    logic [NUM_PERIPH-1:0] pdis;
    logic [1:0] sms;
    logic cosg;
    logic permit;
    logic [2:0] thresh;
    logic wake_irq;
    logic in_low_power;

    // ==========================================================
    // registers
    lp_regs u_regs (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .status_in(c_reg.state),
        .lpc_out(lpc),
        .lpic_out(lpic),
        .pdis_out(pdis)
    );

    assign sms = lpc[SMS_HI:SMS_LO];
    assign cosg = lpc[COSG_BIT];
    assign permit = lpic[STOP_PERMIT_BIT];
    assign thresh = lpic[WPT_HI:WPT_LO];

    // ==========================================================
    // wake qualification
    lp_wake_qualify u_wake (
        .irq_level_in(irq_level_in),
        .irq_unmasked_in(irq_unmasked_in),
        .irq_src_en_in(irq_src_en_in),
        .cpu_mask_level_in(cpu_mask_level_in),
        .threshold_in(thresh),
        .wake_irq_out(wake_irq)
    );

    assign in_low_power = c_reg.state != ST_RUN;

    // ==========================================================
    // mode sequencer
    // the select field is sampled only at the stop instruction, so a
    // later write cannot retarget a mode already entered
    always_comb begin
        c_next = c_reg;
        c_next.wake = 1'b0;
        case (c_reg.state)
            ST_RUN: begin
                if (stop_exec_in) begin
                    case (sms)
                        MODE_DOZE: begin
                            c_next.state = ST_DOZE;
                        end
                        MODE_WAIT: begin
                            c_next.state = ST_WAIT;
                        end
                        MODE_STOP: begin
                            if (permit) begin
                                c_next.state = ST_STOP;
                            end
                        end
                        default: begin
                            c_next.state = ST_RUN;
                        end
                    endcase
                end
            end
            ST_DOZE, ST_WAIT, ST_STOP: begin
                // no reset on exit: peripheral state is retained
                if (wake_irq) begin
                    c_next.state = ST_RUN;
                    c_next.wake = 1'b1;
                end
            end
            default: begin
                c_next.state = ST_RUN;
            end
        endcase
        // enables follow the next state so they line up with it
        c_next.cpu_en = c_next.state == ST_RUN;
        c_next.mem_en = c_next.state == ST_RUN;
        c_next.sys_en = c_next.state != ST_STOP;
        c_next.doze = c_next.state == ST_DOZE;
        c_next.pin_clk_en = !(c_next.state == ST_STOP && cosg);
        c_next.dram_stop = c_next.state == ST_STOP;
        // disable bits are never overridden by a wake
        c_next.periph_en = c_next.sys_en ? ~pdis : '0;
    end

    // reset of any kind returns the block to run
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            c_reg <= CTL_RST;
        end else begin
            c_reg <= c_next;
        end
    end

    assign cpu_clk_en_out = c_reg.cpu_en;
    assign mem_clk_en_out = c_reg.mem_en;
    assign sys_clk_en_out = c_reg.sys_en;
    assign periph_clk_en_out = c_reg.periph_en;
    assign periph_doze_out = c_reg.doze;
    assign clock_output_pin_en_out = c_reg.pin_clk_en;
    assign dram_ctrl_stop_out = c_reg.dram_stop;
    assign wake_out = c_reg.wake;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    run_select_a: assert property (
        c_reg.state == ST_RUN && stop_exec_in && sms == MODE_RUN
        |=> c_reg.state == ST_RUN && cpu_clk_en_out
    ) else $error("run select left run mode");

    mode_entry_a: assert property (
        c_reg.state == ST_RUN && stop_exec_in && sms == MODE_DOZE
        |=> c_reg.state == ST_DOZE && periph_doze_out
            && !cpu_clk_en_out
    ) else $error("doze select did not enter doze");

    wait_entry_a: assert property (
        c_reg.state == ST_RUN && stop_exec_in && sms == MODE_WAIT
        |=> !cpu_clk_en_out && !mem_clk_en_out && sys_clk_en_out
            && !periph_doze_out
    ) else $error("wait entry clocks wrong");

    stop_permit_a: assert property (
        c_reg.state == ST_RUN && stop_exec_in && sms == MODE_STOP
        && permit
        |=> c_reg.state == ST_STOP ##0 !sys_clk_en_out
    ) else $error("permitted stop not entered");

    stop_blocked_a: assert property (
        c_reg.state == ST_RUN && stop_exec_in && sms == MODE_STOP
        && !permit
        |=> c_reg.state == ST_RUN && sys_clk_en_out
    ) else $error("stop entered without permit");

    no_spurious_a: assert property (
        c_reg.state == ST_RUN && !stop_exec_in
        |=> c_reg.state == ST_RUN
    ) else $error("low power entered without stop instruction");

    stop_clocks_a: assert property (
        c_reg.state == ST_STOP
        |-> !sys_clk_en_out && !cpu_clk_en_out && !mem_clk_en_out
            && periph_clk_en_out == '0 && dram_ctrl_stop_out
    ) else $error("clock running in stop");

    lp_clocks_a: assert property (
        in_low_power |-> !cpu_clk_en_out && !mem_clk_en_out
    ) else $error("cpu clock on in low power");

    wake_exit_a: assert property (
        in_low_power && wake_irq
        |=> c_reg.state == ST_RUN && wake_out && cpu_clk_en_out
        ##1 !wake_out
    ) else $error("qualified wake did not return to run");

    hold_mode_a: assert property (
        in_low_power && !wake_irq |=> $stable(c_reg.state) && !wake_out
    ) else $error("low power left without wake");

    thresh_gate_a: assert property (
        in_low_power && irq_level_in < min_wake_level(thresh)
        |=> c_reg.state != ST_RUN
    ) else $error("wake below priority threshold");

    cpu_mask_a: assert property (
        in_low_power && irq_level_in <= cpu_mask_level_in
        |=> $past(c_reg.state) == c_reg.state
    ) else $error("wake at or below cpu mask level");

    src_gate_a: assert property (
        in_low_power && !(irq_unmasked_in && irq_src_en_in)
        |=> !wake_out
    ) else $error("masked or disabled source woke device");

    pin_gate_a: assert property (
        c_reg.state == ST_STOP
        |-> clock_output_pin_en_out == !$past(cosg)
    ) else $error("clock output pin gate wrong in stop");

    periph_off_a: assert property (
        ##1 $past(pdis) != '0
        |-> (periph_clk_en_out & $past(pdis)) == '0
    ) else $error("disabled peripheral clocked");

    stop_exit_a: assert property (
        c_reg.state == ST_STOP && wake_irq
        |=> sys_clk_en_out && periph_clk_en_out == ~$past(pdis)
            && !dram_ctrl_stop_out
    ) else $error("peripherals not resumed after stop");

    doze_cover_c: cover property (
        c_reg.state == ST_RUN ##1 c_reg.state == ST_DOZE
        ##[1:20] wake_out
    );

    stop_cover_c: cover property (
        c_reg.state == ST_STOP ##[1:20] c_reg.state == ST_RUN
    );

    refused_cover_c: cover property (
        stop_exec_in && sms == MODE_STOP && !permit
    );

    wait_cover_c: cover property (
        c_reg.state == ST_WAIT ##1 wake_out
    );

endmodule

// [tb/cpu_irq_model.sv]
`timescale 1ns/1ps
module cpu_irq_model (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // bench requests
    input wire logic stop_req_in,
    input wire logic [2:0] mask_req_in,
    input wire logic [2:0] level_req_in,
    input wire logic unmasked_req_in,
    input wire logic src_en_req_in,
    // block side
    input wire logic cpu_clk_en_in,
    output logic stop_exec_out,
    output logic [2:0] cpu_mask_level_out,
    output logic [2:0] irq_level_out,
    output logic irq_unmasked_out,
    output logic irq_src_en_out
);
    // ==========================================================
    // core: a halted core cannot issue another stop instruction
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            stop_exec_out <= 1'b0;
        end else begin
            stop_exec_out <= stop_req_in && cpu_clk_en_in && !stop_exec_out;
        end
    end

    // ==========================================================
    // interrupt controller: combinational so it works with clocks off
    assign cpu_mask_level_out = mask_req_in;
    assign irq_level_out = level_req_in;
    assign irq_unmasked_out = unmasked_req_in;
    assign irq_src_en_out = src_en_req_in;
endmodule

// [tb/low_power_mode_control_tb.sv]
`timescale 1ns/1ps
module low_power_mode_control_tb;
    import lpm_pkg::*;
    logic clk_sys_in, rst_in, reg_wr, reg_rd, stop_req, stop_exec;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, rdata;
    logic unm_req, en_req, irq_unm, irq_en, g;
    logic [2:0] mask_req, lvl_req, cpu_mask, irq_lvl;
    logic cpu_en, mem_en, sys_en, doze, pin_clk_en, dram_stop, wake;
    logic [NUM_PERIPH-1:0] periph_en;
    logic [7:0] lpc, lpic, pdis;
    logic [1:0] sm;
    int bad_count, n_compared, wake_cnt, mode, w0;

    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    cpu_irq_model partner (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .stop_req_in(stop_req), .mask_req_in(mask_req),
        .level_req_in(lvl_req), .unmasked_req_in(unm_req),
        .src_en_req_in(en_req), .cpu_clk_en_in(cpu_en),
        .stop_exec_out(stop_exec), .cpu_mask_level_out(cpu_mask),
        .irq_level_out(irq_lvl), .irq_unmasked_out(irq_unm),
        .irq_src_en_out(irq_en));

    low_power_mode_control dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .stop_exec_in(stop_exec), .cpu_mask_level_in(cpu_mask),
        .irq_level_in(irq_lvl), .irq_unmasked_in(irq_unm),
        .irq_src_en_in(irq_en), .cpu_clk_en_out(cpu_en),
        .mem_clk_en_out(mem_en), .sys_clk_en_out(sys_en),
        .periph_clk_en_out(periph_en), .periph_doze_out(doze),
        .clock_output_pin_en_out(pin_clk_en),
        .dram_ctrl_stop_out(dram_stop), .wake_out(wake));

    always @(posedge clk_sys_in) begin
        if (wake === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end

    // ==========================================================
    // checking and reporting
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        bad_count++;
        $display("mismatch at %0t: run timed out", $time);
        close_out();
    end

    // ==========================================================
    // register bus and model
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
        if (a == OFS_LOW_POWER_CONTROL) lpc = d & 8'hc8;
        if (a == OFS_LOW_POWER_IRQ_CONTROL) lpic = d & 8'hf0;
        if (a == OFS_PERIPH_DISABLE) pdis = d;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    task automatic check_outs;
        check(8'(cpu_en), 8'(mode == 0));
        check(8'(mem_en), 8'(mode == 0));
        check(8'(sys_en), 8'(mode != 3));
        check(periph_en, mode == 3 ? 8'h00 : ~pdis);
        check(8'(doze), 8'(mode == 1));
        check(8'(pin_clk_en), 8'(mode != 3 || !lpc[3]));
        check(8'(dram_stop), 8'(mode == 3));
        reg_read(OFS_STATUS, 8'(1 << mode));
    endtask

    task automatic enter;
        @(posedge clk_sys_in);
        stop_req <= 1'b1;
        @(posedge clk_sys_in);
        stop_req <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        #1;
        if (mode == 0 && !(lpc[7:6] == 2'h3 && !lpic[7])) begin
            mode = int'(lpc[7:6]);
        end
        check_outs();
    endtask

    function automatic int need(input int thr);
        return thr == 0 ? 1 : (thr >= 6 ? 7 : thr + 1);
    endfunction

    task automatic wake_try(input int l, input int m, input logic u,
                            input logic e);
        logic q;
        q = mode != 0 && l >= need(int'(lpic[6:4])) && l > m && u && e;
        w0 = wake_cnt;
        @(posedge clk_sys_in);
        lvl_req <= 3'(l);
        mask_req <= 3'(m);
        unm_req <= u;
        en_req <= e;
        repeat (3) @(posedge clk_sys_in);
        #1;
        if (q) mode = 0;
        check(8'(wake_cnt - w0), 8'(q));
        @(posedge clk_sys_in);
        lvl_req <= 3'h0;
        check_outs();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_in = 1'b1;
        {reg_wr, reg_rd, stop_req, unm_req, en_req} = 5'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        {mask_req, lvl_req} = 6'h00;
        {lpc, lpic, pdis} = 24'h0000_00;
        {bad_count, n_compared, mode} = {3{32'h0000_0000}};
        void'($urandom(80));
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        check_outs();
        reg_read(OFS_LOW_POWER_CONTROL, 8'h00);
        reg_read(OFS_LOW_POWER_IRQ_CONTROL, 8'h00);
        reg_read(4'hf, 8'h00);
        $display("test reset done");

        reg_write(OFS_LOW_POWER_CONTROL, 8'hff);
        reg_read(OFS_LOW_POWER_CONTROL, 8'hc8);
        reg_write(OFS_LOW_POWER_IRQ_CONTROL, 8'hff);
        reg_read(OFS_LOW_POWER_IRQ_CONTROL, 8'hf0);
        reg_write(4'hf, 8'h55);
        reg_read(4'hf, 8'h00);
        reg_write(OFS_STATUS, 8'hff);
        reg_read(OFS_STATUS, 8'h01);
        $display("test access done");

        for (int m = 0; m < 8; m++) begin
            sm = 2'(m >> 1);
            g = 1'($urandom);
            reg_write(OFS_LOW_POWER_IRQ_CONTROL, {1'(m), 7'h00});
            reg_write(OFS_LOW_POWER_CONTROL, {sm, 2'h0, g, 3'h0});
            reg_write(OFS_PERIPH_DISABLE, 8'($urandom));
            enter();
            // a late write must not change the mode already entered
            reg_write(OFS_LOW_POWER_CONTROL, {~sm, 2'h0, ~g, 3'h0});
            reg_read(OFS_LOW_POWER_CONTROL, lpc);
            check_outs();
            wake_try(7, 0, 1'b1, 1'b1);
        end
        $display("test modes done");

        for (int i = 0; i < 40; i++) begin
            reg_write(OFS_LOW_POWER_IRQ_CONTROL, {1'b1, 3'(i), 4'h0});
            reg_write(OFS_LOW_POWER_CONTROL, {2'(1 + i % 3), 6'h00});
            enter();
            wake_try($urandom % 8, $urandom % 8, 1'($urandom),
                     1'($urandom));
            wake_try(7, 0, 1'b1, 1'b1);
        end
        $display("test wake qualify done");

        reg_write(OFS_LOW_POWER_IRQ_CONTROL, 8'h80);
        reg_write(OFS_LOW_POWER_CONTROL, 8'hc8);
        enter();
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        {mode, lpc, lpic, pdis} = {32'h0000_0000, 24'h0000_00};
        #1;
        check_outs();
        reg_read(OFS_LOW_POWER_CONTROL, 8'h00);
        $display("test reset wake done");
        close_out();
    end
endmodule
